// file: spp_program_port.sv
`timescale 1ns/1ps
`include "spp_regs.svh"

module spp_program_port #(
   parameter int unsigned TUNE_CYCLES = `SPP_TUNE_CYCLES
) (
   // Clocks and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Serial link
   input wire logic sclk_link,
   input wire logic serial_enable_n,
   input wire logic serial_data_in,
   // Device pins
   input wire logic powerdown_pin_n,
   output logic auxiliary_output_pin,
   output logic lock_warning_n,
   // Analog loop side
   input wire logic rf_near_limit,
   input wire logic if_near_limit,
   output spp_pkg::spp_ctrl_s loop_ctrl
);

   localparam logic [12:0] TUNE_LAST = 13'(TUNE_CYCLES - 1);

   spp_pkg::spp_link_s lnk, nxt_lnk;
   spp_pkg::spp_sys_s st, nxt_st;

   logic sen_rise;
   logic [3:0] waddr;
   logic [17:0] wdata;
   logic rf_on;
   logic if_on;
   logic if_ok;

   // Link domain: the shifter only moves on the host's clock
   always_comb begin
      nxt_lnk = lnk;
      if (!serial_enable_n) begin
         nxt_lnk.shift = {lnk.shift[20:0], serial_data_in};
      end
   end

   always_ff @(posedge sclk_link or negedge resetn) begin
      if (!resetn) begin
         lnk <= '0;
      end else begin
         lnk <= nxt_lnk;
      end
   end

   // The shifter is quiet while enable is high, so its word is read here
   // only after the synchronised rising edge; host must leave enable high
   // for at least four system clocks before the next frame.
   assign sen_rise = st.sen_s2 & ~st.sen_s3;
   assign waddr = lnk.shift[`SPP_ADDR_LSB +: `SPP_ADDR_W];
   assign wdata = lnk.shift[`SPP_DATA_LSB +: `SPP_DATA_W];
   assign rf_on = st.pd_s2 & (st.autopd | st.pd_rf);
   assign if_on = st.pd_s2 & (st.autopd | st.pd_if);
   assign if_ok = (wdata[15:0] == `SPP_IF_N_LO) || (wdata[15:0] == `SPP_IF_N_MID) ||
      (wdata[15:0] == `SPP_IF_N_HI);

   function automatic spp_pkg::spp_tune_s tune_next(input spp_pkg::spp_tune_s cur,
         input logic on, input logic start);
      tune_next = cur;
      if (!on) begin
         tune_next.stage = spp_pkg::TUNE_OFF;
         tune_next.cnt = '0;
      end else if (start) begin
         tune_next.stage = spp_pkg::TUNE_RUN;
         tune_next.cnt = '0;
      end else begin
         case (cur.stage)
            spp_pkg::TUNE_OFF: begin
               tune_next.stage = spp_pkg::TUNE_RUN;
               tune_next.cnt = '0;
            end
            spp_pkg::TUNE_RUN: begin
               if (cur.cnt == TUNE_LAST) begin
                  tune_next.stage = spp_pkg::TUNE_LOCK;
               end else begin
                  tune_next.cnt = cur.cnt + 13'h0001;
               end
            end
            spp_pkg::TUNE_LOCK: begin
               tune_next.stage = spp_pkg::TUNE_LOCK;
            end
            default: begin
               tune_next.stage = spp_pkg::TUNE_OFF;
               tune_next.cnt = '0;
            end
         endcase
      end
   endfunction

   always_comb begin
      logic rf_new;
      logic if_new;
      rf_new = 1'b0;
      if_new = 1'b0;
      nxt_st = st;
      nxt_st.sen_s1 = serial_enable_n;
      nxt_st.sen_s2 = st.sen_s1;
      nxt_st.sen_s3 = st.sen_s2;
      nxt_st.pd_s1 = powerdown_pin_n;
      nxt_st.pd_s2 = st.pd_s1;
      nxt_st.lim_s1 = {rf_near_limit, if_near_limit};
      nxt_st.lim_s2 = st.lim_s1;
      if (sen_rise) begin
         case (waddr)
            `SPP_A_MAIN: begin
               nxt_st.auxsel = wdata[`SPP_AUXSEL_LSB +: 2];
               nxt_st.autopd = wdata[`SPP_AUTOPD_BIT];
            end
            `SPP_A_PWR: begin
               nxt_st.pd_if = wdata[`SPP_PDIF_BIT];
               nxt_st.pd_rf = wdata[`SPP_PDRF_BIT];
            end
            `SPP_A_RF1: begin
               nxt_st.n_rf1 = wdata;
               nxt_st.rf_sel = 1'b0;
               rf_new = 1'b1;
            end
            `SPP_A_RF2: begin
               nxt_st.n_rf2 = wdata[`SPP_RF2_N_W-1:0];
               nxt_st.rf_sel = 1'b1;
               rf_new = 1'b1;
            end
            `SPP_A_IF: begin
               if (if_ok) begin
                  nxt_st.n_if = wdata[`SPP_IF_N_W-1:0];
                  if_new = 1'b1;
               end
            end
            default: begin
               nxt_st.rf_sel = st.rf_sel;
            end
         endcase
      end
      nxt_st.rf_tune = tune_next(st.rf_tune, rf_on, rf_new);
      nxt_st.if_tune = tune_next(st.if_tune, if_on, if_new);
      nxt_st.ctrl.prim_en = rf_on & ~st.rf_sel;
      nxt_st.ctrl.sec_en = rf_on & st.rf_sel;
      nxt_st.ctrl.if_en = if_on;
      nxt_st.ctrl.rf_tuning = (st.rf_tune.stage == spp_pkg::TUNE_RUN);
      nxt_st.ctrl.if_tuning = (st.if_tune.stage == spp_pkg::TUNE_RUN);
      nxt_st.ctrl.rf_n = st.rf_sel ? {1'b0, st.n_rf2} : st.n_rf1;
      nxt_st.ctrl.if_n = st.n_if;
      // Warning covers tuning in progress and a powered loop near its range edge
      nxt_st.warn = nxt_st.ctrl.rf_tuning | nxt_st.ctrl.if_tuning |
         (rf_on & st.lim_s2[1]) | (if_on & st.lim_s2[0]);
      nxt_st.aux = (st.auxsel == `SPP_AUX_WARN) ? st.warn : 1'b0;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.sen_s1 <= 1'b1;
         st.sen_s2 <= 1'b1;
         st.sen_s3 <= 1'b1;
         st.auxsel <= `SPP_RST_AUXSEL;
         st.autopd <= `SPP_RST_AUTOPD;
         st.pd_if <= `SPP_RST_PDIF;
         st.pd_rf <= `SPP_RST_PDRF;
         st.n_rf1 <= `SPP_RST_N_RF1;
         st.n_rf2 <= `SPP_RST_N_RF2;
         st.n_if <= `SPP_RST_N_IF;
         st.ctrl.if_n <= `SPP_RST_N_IF;
      end else begin
         st <= nxt_st;
      end
   end

   assign loop_ctrl = st.ctrl;
   assign lock_warning_n = st.warn;
   assign auxiliary_output_pin = st.aux;

   // Checks, link domain
   property p_shift_in;
      @(posedge sclk_link) disable iff (!resetn)
      !serial_enable_n |=> lnk.shift[0] == $past(serial_data_in);
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("bit not shifted in");

   property p_idle_hold;
      @(posedge sclk_link) disable iff (!resetn)
      serial_enable_n |=> lnk.shift == $past(lnk.shift);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("shifter moved while idle");

   // Checks, system domain
   sequence s_rf1_write;
      sen_rise && waddr == `SPP_A_RF1;
   endsequence

   property p_rf1_commit;
      @(posedge clk_sys) disable iff (!resetn)
      s_rf1_write |=> st.n_rf1 == $past(wdata) && !st.rf_sel ##1 !loop_ctrl.sec_en;
   endproperty
   a_rf1_commit: assert property (p_rf1_commit) else $error("primary divider not committed");

   property p_rf2_select;
      @(posedge clk_sys) disable iff (!resetn)
      sen_rise && waddr == `SPP_A_RF2 |=> st.rf_sel ##1 !loop_ctrl.prim_en;
   endproperty
   a_rf2_select: assert property (p_rf2_select) else $error("secondary loop not selected");

   property p_unknown_addr;
      @(posedge clk_sys) disable iff (!resetn)
      sen_rise && (waddr == 4'h1 || waddr > `SPP_A_IF) |=>
         $stable({st.auxsel, st.autopd, st.pd_if, st.pd_rf, st.rf_sel, st.n_rf1, st.n_rf2,
            st.n_if});
   endproperty
   a_unknown_addr: assert property (p_unknown_addr) else $error("unknown address wrote");

   property p_one_rf;
      @(posedge clk_sys) disable iff (!resetn)
      !(loop_ctrl.prim_en && loop_ctrl.sec_en);
   endproperty
   a_one_rf: assert property (p_one_rf) else $error("both RF loops active");

   property p_pin_off;
      @(posedge clk_sys) disable iff (!resetn)
      !st.pd_s2 |=> !loop_ctrl.prim_en && !loop_ctrl.sec_en && !loop_ctrl.if_en;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("loop on with pin low");

   property p_if_values;
      @(posedge clk_sys) disable iff (!resetn)
      st.n_if == `SPP_IF_N_LO || st.n_if == `SPP_IF_N_MID || st.n_if == `SPP_IF_N_HI;
   endproperty
   a_if_values: assert property (p_if_values) else $error("illegal IF setting");

   property p_power_tune;
      @(posedge clk_sys) disable iff (!resetn)
      rf_on && st.rf_tune.stage == spp_pkg::TUNE_OFF |=> st.rf_tune.stage == spp_pkg::TUNE_RUN
         ##1 loop_ctrl.rf_tuning && lock_warning_n ##1 lock_warning_n;
   endproperty
   a_power_tune: assert property (p_power_tune) else $error("no tuning at power-up");

   property p_tune_len;
      @(posedge clk_sys) disable iff (!resetn)
      $fell(st.rf_tune.stage == spp_pkg::TUNE_RUN) && rf_on |->
         st.rf_tune.stage == spp_pkg::TUNE_LOCK && $past(st.rf_tune.cnt) == TUNE_LAST;
   endproperty
   a_tune_len: assert property (p_tune_len) else $error("tuning length wrong");

   property p_aux_sel;
      @(posedge clk_sys) disable iff (!resetn)
      st.auxsel != `SPP_AUX_WARN |=> !auxiliary_output_pin;
   endproperty
   a_aux_sel: assert property (p_aux_sel) else $error("aux output not low");

   // A divider write to a powered loop restarts tuning even at the same value
   sequence s_rf_div_write;
      sen_rise && (waddr == `SPP_A_RF1 || waddr == `SPP_A_RF2);
   endsequence

   property p_freq_tune;
      @(posedge clk_sys) disable iff (!resetn)
      s_rf_div_write ##0 rf_on |=>
         st.rf_tune.stage == spp_pkg::TUNE_RUN && st.rf_tune.cnt == 13'h0000;
   endproperty
   a_freq_tune: assert property (p_freq_tune) else $error("new frequency not retuned");

   sequence s_if_write;
      sen_rise && waddr == `SPP_A_IF;
   endsequence

   property p_if_commit;
      @(posedge clk_sys) disable iff (!resetn)
      s_if_write ##0 wdata[15:0] inside {`SPP_IF_N_LO, `SPP_IF_N_MID, `SPP_IF_N_HI} |=>
         st.n_if == $past(wdata[15:0]);
   endproperty
   a_if_commit: assert property (p_if_commit) else $error("IF setting not committed");

   property p_if_reject;
      @(posedge clk_sys) disable iff (!resetn)
      s_if_write ##0 !(wdata[15:0] inside {`SPP_IF_N_LO, `SPP_IF_N_MID, `SPP_IF_N_HI}) |=>
         $stable(st.n_if);
   endproperty
   a_if_reject: assert property (p_if_reject) else $error("illegal IF setting taken");

   property p_main_commit;
      @(posedge clk_sys) disable iff (!resetn)
      sen_rise && waddr == `SPP_A_MAIN |=>
         st.auxsel == $past(wdata[13:12]) && st.autopd == $past(wdata[`SPP_AUTOPD_BIT]);
   endproperty
   a_main_commit: assert property (p_main_commit) else $error("main setup not committed");

   // Warning must cover the whole tuning window
   property p_warn_tuning;
      @(posedge clk_sys) disable iff (!resetn)
      loop_ctrl.rf_tuning || loop_ctrl.if_tuning |-> lock_warning_n;
   endproperty
   a_warn_tuning: assert property (p_warn_tuning) else $error("no warning while tuning");

   property p_tune_cnt;
      @(posedge clk_sys) disable iff (!resetn)
      st.rf_tune.cnt <= TUNE_LAST && st.if_tune.cnt <= TUNE_LAST;
   endproperty
   a_tune_cnt: assert property (p_tune_cnt) else $error("tuning count overran");

endmodule

// file: spp_regs.svh
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH

// Serial word layout, address in the last four bits shifted
`define SPP_WORD_W 22
`define SPP_DATA_W 18
`define SPP_ADDR_W 4
`define SPP_ADDR_LSB 0
`define SPP_DATA_LSB 4

// Internal register addresses
`define SPP_A_MAIN 4'h0
`define SPP_A_PWR 4'h2
`define SPP_A_RF1 4'h3
`define SPP_A_RF2 4'h4
`define SPP_A_IF 4'h5

// Field positions
`define SPP_AUXSEL_LSB 12
`define SPP_AUTOPD_BIT 3
`define SPP_PDIF_BIT 1
`define SPP_PDRF_BIT 0
`define SPP_RF2_N_W 17
`define SPP_IF_N_W 16

// Auxiliary output selections
`define SPP_AUX_LOW 2'h1
`define SPP_AUX_WARN 2'h3

// Intermediate-frequency divider settings: 1070.4, 1080, 1089.6 MHz
`define SPP_IF_N_LO 16'h14E8
`define SPP_IF_N_MID 16'h1518
`define SPP_IF_N_HI 16'h1548

// Reset values
`define SPP_RST_AUXSEL 2'h0
`define SPP_RST_AUTOPD 1'h0
`define SPP_RST_PDIF 1'h0
`define SPP_RST_PDRF 1'h0
`define SPP_RST_N_RF1 18'h00000
`define SPP_RST_N_RF2 17'h00000
`define SPP_RST_N_IF `SPP_IF_N_MID

// Timing: 6.5 update periods of 5 us, clock period 5 ns
`define SPP_CLK_PERIOD_NS 5
`define SPP_UPD_PERIOD_US 5
`define SPP_TUNE_PERIODS_X10 65
`define SPP_TUNE_CYCLES ((`SPP_TUNE_PERIODS_X10 * `SPP_UPD_PERIOD_US * 1000 + \
   10 * `SPP_CLK_PERIOD_NS - 1) / (10 * `SPP_CLK_PERIOD_NS))
`define SPP_TUNE_CNT_W 13

`endif

// file: spp_pkg.sv
package spp_pkg;

   typedef enum logic [1:0] {TUNE_OFF, TUNE_RUN, TUNE_LOCK} spp_tune_e;

   typedef struct packed {
      spp_tune_e stage;
      logic [12:0] cnt;
   } spp_tune_s;

   typedef struct packed {
      logic prim_en;
      logic sec_en;
      logic if_en;
      logic rf_tuning;
      logic if_tuning;
      logic [17:0] rf_n;
      logic [15:0] if_n;
   } spp_ctrl_s;

   typedef struct packed {
      logic [21:0] shift;
   } spp_link_s;

   typedef struct packed {
      logic sen_s1;
      logic sen_s2;
      logic sen_s3;
      logic pd_s1;
      logic pd_s2;
      logic [1:0] lim_s1;
      logic [1:0] lim_s2;
      logic [1:0] auxsel;
      logic autopd;
      logic pd_if;
      logic pd_rf;
      logic rf_sel;
      logic [17:0] n_rf1;
      logic [16:0] n_rf2;
      logic [15:0] n_if;
      spp_tune_s rf_tune;
      spp_tune_s if_tune;
      spp_ctrl_s ctrl;
      logic warn;
      logic aux;
   } spp_sys_s;

endpackage

// file: spp_host_model.sv
`timescale 1ns/1ps
module spp_host_model (
   // Serial lines to the device
   output logic sclk_link,
   output logic serial_enable_n,
   output logic serial_data_in
);
   initial begin
      sclk_link = 1'b0;
      serial_enable_n = 1'b1;
      serial_data_in = 1'b0;
   end

   // MSB first, address bits last, extra leading bits allowed
   task automatic send(input logic [31:0] word, input int nbits);
      #1.3 serial_enable_n = 1'b0;
      #10;
      for (int i = nbits - 1; i >= 0; i--) begin
         serial_data_in = word[i];
         #7.5 sclk_link = 1'b1;
         #7.5 sclk_link = 1'b0;
      end
      #7.5 serial_enable_n = 1'b1;
      // Released line flips so a stale bit never looks valid
      serial_data_in = ~serial_data_in;
      #25;
   endtask

   // Clock and data activity with the enable left high
   task automatic noise(input logic [31:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         serial_data_in = bits[i];
         #7.5 sclk_link = 1'b1;
         #7.5 sclk_link = 1'b0;
      end
   endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`include "spp_regs.svh"
module tb_top;
   logic clk_sys, resetn, powerdown_pin_n, rf_near_limit, if_near_limit;
   logic sclk_link, serial_enable_n, serial_data_in, auxiliary_output_pin, lock_warning_n;
   spp_pkg::spp_ctrl_s loop_ctrl;
   int err_count;
   int total_checks;
   logic [31:0] rnd;
   // Reference copy of the device registers
   logic pin, autopd, pd_if, pd_rf, rf_sel;
   logic [1:0] auxsel;
   logic [17:0] n_rf1;
   logic [16:0] n_rf2;
   logic [15:0] n_if;
   logic [15:0] if_vals [4];

   spp_program_port #(.TUNE_CYCLES(20)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
      .sclk_link(sclk_link), .serial_enable_n(serial_enable_n),
      .serial_data_in(serial_data_in), .powerdown_pin_n(powerdown_pin_n),
      .auxiliary_output_pin(auxiliary_output_pin), .lock_warning_n(lock_warning_n),
      .rf_near_limit(rf_near_limit), .if_near_limit(if_near_limit), .loop_ctrl(loop_ctrl));
   spp_host_model i_host (.sclk_link(sclk_link), .serial_enable_n(serial_enable_n),
      .serial_data_in(serial_data_in));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic rf_on();
      return pin & (autopd | pd_rf);
   endfunction
   function automatic logic if_on();
      return pin & (autopd | pd_if);
   endfunction
   // Aux pin, warning, then loop controls
   function automatic logic [40:0] exp_out(input logic trf, input logic tif, input logic lim);
      spp_pkg::spp_ctrl_s c;
      logic warn;
      c.prim_en = rf_on() & ~rf_sel;
      c.sec_en = rf_on() & rf_sel;
      c.if_en = if_on();
      c.rf_tuning = trf;
      c.if_tuning = tif;
      c.rf_n = rf_sel ? {1'b0, n_rf2} : n_rf1;
      c.if_n = n_if;
      warn = trf | tif | lim;
      return {(auxsel == 2'h3) & warn, warn, c};
   endfunction

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic look(input logic trf, input logic tif, input logic lim);
      logic [40:0] exp;
      exp = exp_out(trf, tif, lim);
      total_checks++;
      if ({auxiliary_output_pin, lock_warning_n, loop_ctrl} !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time,
            {auxiliary_output_pin, lock_warning_n, loop_ctrl}, exp);
      end
   endtask
   // Sample mid-cycle so edge updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic wr(input logic [3:0] a, input logic [17:0] d);
      logic r0, i0, ok_if, trf, tif;
      r0 = rf_on();
      i0 = if_on();
      ok_if = (a == `SPP_A_IF) && (d[15:0] inside {`SPP_IF_N_LO, `SPP_IF_N_MID, `SPP_IF_N_HI});
      rnd = lfsr(rnd);
      i_host.send({rnd[9:0], d, a}, 22 + int'(rnd[12:10]));
      case (a)
         `SPP_A_MAIN: begin
            auxsel = d[13:12];
            autopd = d[3];
         end
         `SPP_A_PWR: begin
            pd_if = d[1];
            pd_rf = d[0];
         end
         `SPP_A_RF1: begin
            n_rf1 = d;
            rf_sel = 1'b0;
         end
         `SPP_A_RF2: begin
            n_rf2 = d[16:0];
            rf_sel = 1'b1;
         end
         `SPP_A_IF: if (ok_if) n_if = d[15:0];
         default: ;
      endcase
      trf = rf_on() & (~r0 | a == `SPP_A_RF1 | a == `SPP_A_RF2);
      tif = if_on() & (~i0 | ok_if);
      cyc(3);
      look(trf, tif, 1'b0);
      cyc(40);
      look(1'b0, 1'b0, 1'b0);
   endtask

   initial begin
      #200000;
      err_count++;
      end_of_test();
   end

   initial begin
      {resetn, rf_near_limit, if_near_limit} = 3'h0;
      powerdown_pin_n = 1'b1;
      err_count = 0;
      total_checks = 0;
      rnd = 32'hF5C8B9C9;
      if_vals = '{`SPP_IF_N_HI, `SPP_IF_N_LO, 16'h1519, `SPP_IF_N_MID};
      {pin, autopd, pd_if, pd_rf, rf_sel, auxsel, n_rf1, n_rf2} = {5'h10, 2'h0, 18'h0, 17'h0};
      n_if = `SPP_IF_N_MID;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      cyc(1);
      look(1'b0, 1'b0, 1'b0);
      wr(`SPP_A_RF1, 18'h2A5C3);
      wr(`SPP_A_PWR, 18'h00003);
      $display("power-up test done");
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         wr(rnd[20] ? `SPP_A_RF2 : `SPP_A_RF1, rnd[17:0]);
      end
      $display("rf divider test done");
      for (int i = 0; i < 4; i++) begin
         wr(`SPP_A_IF, {2'h0, if_vals[i]});
      end
      $display("if setting test done");
      for (int a = 1; a < 16; a++) begin
         rnd = lfsr(rnd);
         if (a == 1 || a > 5) wr(4'(a), rnd[17:0]);
      end
      i_host.noise(rnd, 16);
      cyc(6);
      look(1'b0, 1'b0, 1'b0);
      $display("ignore test done");
      wr(`SPP_A_MAIN, 18'h03000);
      for (int k = 0; k < 3; k++) begin
         if (k == 2) wr(`SPP_A_MAIN, 18'h01000);
         @(posedge clk_sys) {rf_near_limit, if_near_limit} <= (k == 1) ? 2'h1 : 2'h2;
         cyc(6);
         look(1'b0, 1'b0, 1'b1);
         @(posedge clk_sys) {rf_near_limit, if_near_limit} <= 2'h0;
         cyc(6);
      end
      $display("warning test done");
      @(posedge clk_sys) powerdown_pin_n <= 1'b0;
      pin = 1'b0;
      cyc(6);
      look(1'b0, 1'b0, 1'b0);
      @(posedge clk_sys) powerdown_pin_n <= 1'b1;
      pin = 1'b1;
      cyc(6);
      look(rf_on(), if_on(), 1'b0);
      cyc(40);
      wr(`SPP_A_PWR, 18'h00000);
      wr(`SPP_A_MAIN, 18'h03008);
      $display("power test done");
      end_of_test();
   end
endmodule
